// ---- rtl/dtss_seq.sv ----
`timescale 1ns/1ps
module dtss_seq
   import dtss_pkg::*;
#(
   parameter int NUM_CH = DTSS_NUM_CH,
   parameter int CTL_W = DTSS_CTL_W
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic arm,
   input wire logic [CTL_W-1:0] sequencer_state_ctl1,
   input wire logic [CTL_W-1:0] sequencer_state_ctl2,
   input wire logic [CTL_W-1:0] sequencer_state_ctl3,
   input wire logic match_ch0,
   input wire logic match_ch1,
   input wire logic match_ch2,
   input wire logic range_ab,
   input wire logic [2:0] tag_en,
   input wire logic [2:0] tag_hit,
   input wire logic brk_en,
   output logic [2:0] tag_req,
   output logic [2:0] seq_state,
   output logic in_final,
   output logic brk_req
);
   // =============================
   // elaboration checks
   if (NUM_CH != DTSS_NUM_CH || CTL_W != DTSS_CTL_W) begin : g_bad
      $error("dtss_seq supports three channels and four-bit control words");
   end

   // =============================
   // channel transition decode
   // target of one channel from one state under one control word
   function automatic dtss_tgt_t chan_tgt(dtss_state_t st, logic [CTL_W-1:0] ctl, int c);
      dtss_tgt_t t;
      dtss_state_t nx;
      dtss_state_t alt;
      logic [2:0] code;
      t.hit = 1'b0;
      t.nxt = st;
      code = ctl[DTSS_CTL_CODE_LSB +: 3];
      // the natural successor of each state
      case (st)
         DTSS_S1: begin
            nx = DTSS_S2;
            alt = DTSS_S3;
         end
         DTSS_S2: begin
            nx = DTSS_S3;
            alt = DTSS_S1;
         end
         DTSS_S3: begin
            nx = DTSS_FINAL;
            alt = DTSS_S2;
         end
         default: begin
            nx = st;
            alt = st;
         end
      endcase
      // legacy three-bit meaning, untouched by the extra bit
      case (code)
         DTSS_C_CH0_NEXT: if (c == 0) t = '{1'b1, nx};
         DTSS_C_CH1_NEXT: if (c == 1) t = '{1'b1, nx};
         DTSS_C_CH2_NEXT: if (c == 2) t = '{1'b1, nx};
         DTSS_C_CH0_FIN: if (c == 0) t = '{1'b1, DTSS_FINAL};
         DTSS_C_CH1_FIN: if (c == 1) t = '{1'b1, DTSS_FINAL};
         DTSS_C_CH2_FIN: if (c == 2) t = '{1'b1, DTSS_FINAL};
         DTSS_C_CH0N_CH1F: begin
            if (c == 0) t = '{1'b1, nx};
            if (c == 1) t = '{1'b1, DTSS_FINAL};
         end
         DTSS_C_CH1N_CH2F: begin
            if (c == 1) t = '{1'b1, nx};
            if (c == 2) t = '{1'b1, DTSS_FINAL};
         end
         default: t.hit = 1'b0;
      endcase
      // extra bit: channel 0 goes to the alternate state instead of its legacy target,
      // so range compares (channel 0 only) reach every state
      if (ctl[DTSS_CTL_ALT_BIT] && c == 0) begin
         t = '{1'b1, alt};
      end
      return t;
   endfunction

   // =============================
   // carrier to the tag trackers
   dtss_chan_if chi ();
   // channel 1 is masked in range mode; a and c stay independent
   assign chi.match = {match_ch2, match_ch1 & ~range_ab, match_ch0};
   assign chi.tag_en = tag_en;
   assign chi.tag_hit = tag_hit;
   assign chi.armed = arm;
   assign tag_req = chi.tag_req;

   dtss_tag_track #(.NUM_CH(NUM_CH)) u_trk (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ch(chi.trk)
   );

   // =============================
   // sequencer state
   dtss_state_t state_r;    // current sequencer state
   dtss_state_t state_nxt;
   logic arm_r;             // arm seen last cycle
   logic brk_r;             // breakpoint request pulse
   logic brk_nxt;
   logic [CTL_W-1:0] ctl_cur;    // control word of current state
   dtss_tgt_t tgt [NUM_CH];      // per-channel candidate
   logic fin_any;                // some hit leads to final

   // select control word for the current state
   always_comb begin
      case (state_r)
         DTSS_S1: ctl_cur = sequencer_state_ctl1;
         DTSS_S2: ctl_cur = sequencer_state_ctl2;
         DTSS_S3: ctl_cur = sequencer_state_ctl3;
         default: ctl_cur = DTSS_CTL_RST;
      endcase
   end

   // candidates only from channels with a live event
   genvar g;
   for (g = 0; g < NUM_CH; g++) begin : g_tgt
      dtss_tgt_t raw;
      assign raw = chan_tgt(state_r, ctl_cur, g);
      assign tgt[g] = '{raw.hit & chi.evt[g], raw.nxt};
   end

   // next state with fixed priority
   always_comb begin
      state_nxt = state_r;
      fin_any = 1'b0;
      brk_nxt = 1'b0;
      for (int k = 0; k < NUM_CH; k++) begin
         if (tgt[k].hit && tgt[k].nxt == DTSS_FINAL) fin_any = 1'b1;
      end
      if (!arm) begin
         state_nxt = DTSS_IDLE;
      end else if (!arm_r || state_r == DTSS_IDLE) begin
         state_nxt = DTSS_S1;     // fresh arming; matches ignored
      end else if (state_r == DTSS_FINAL) begin
         state_nxt = DTSS_FINAL;  // held until disarm
      end else if (fin_any) begin
         state_nxt = DTSS_FINAL;
      end else begin
         // lowest numbered channel wins, so scan downward
         for (int k = NUM_CH - 1; k >= 0; k--) begin
            if (tgt[k].hit) state_nxt = tgt[k].nxt;
         end
      end
      // one request on the way into final
      if (state_nxt == DTSS_FINAL && state_r != DTSS_FINAL) begin
         brk_nxt = brk_en;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state_r <= DTSS_IDLE;
         arm_r <= 1'b0;
         brk_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         arm_r <= arm;
         brk_r <= brk_nxt;
      end
   end

   assign seq_state = state_r;
   assign in_final = (state_r == DTSS_FINAL);
   assign brk_req = brk_r;

   // =============================
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence s_run(dtss_state_t s);
      arm && arm_r && state_r == s;
   endsequence

   disarm_idle_a: assert property (!arm |=> state_r == DTSS_IDLE)
      else $error("disarm did not return to idle");
   // the cycle after arming is already live, so only that one edge is checked
   arm_start_a: assert property (arm && !arm_r |=> state_r == DTSS_S1)
      else $error("arming did not start in state1");
   final_hold_a: assert property (s_run(DTSS_FINAL) ##1 arm |-> in_final)
      else $error("final state left while armed");
   range_mask_a: assert property (range_ab && !tag_en[1] |-> !chi.evt[1])
      else $error("channel 1 event under range mode");
   // the run sequence is fused with the extra terms, never and-ed with them
   quiet_stay_a: assert property (s_run(DTSS_S2) ##0 (chi.evt == 3'h0)
      |=> state_r == DTSS_S2)
      else $error("state moved without an event");
   final_prio_a: assert property (s_run(DTSS_S3) ##0 (sequencer_state_ctl3 == 4'hD
      && chi.evt[0] && chi.evt[2]) |=> in_final)
      else $error("final-bound hit lost priority");
   s3_return_a: assert property (s_run(DTSS_S3) ##0 (sequencer_state_ctl3 == 4'hD
      && chi.evt == 3'h1) |=> state_r == DTSS_S2)
      else $error("channel 0 did not return state3 to state2");
   low_prio_a: assert property (s_run(DTSS_S1) ##0 (sequencer_state_ctl1 == 4'h9
      && chi.evt == 3'h3) |=> state_r == DTSS_S3)
      else $error("lowest channel did not decide");
   s1_jump_a: assert property (s_run(DTSS_S1) ##0 (sequencer_state_ctl1[3]
      && chi.evt == 3'h1) |=> state_r == DTSS_S3)
      else $error("channel 0 did not jump state1 to state3");
   brk_pulse_a: assert property (brk_en && arm && arm_r
      && state_r inside {DTSS_S1, DTSS_S2, DTSS_S3}
      ##1 in_final |-> brk_req ##1 !brk_req)
      else $error("breakpoint request not a single pulse on final entry");
endmodule

// ---- rtl/dtss_pkg.sv ----
// Overview of operation
// - three control words and three matches steer states
// - fourth control bit adds options, low three unchanged
// - range mode on a and b masks channel 1
// - hits leading to final state win ties
// - otherwise lowest numbered channel decides next state
// - state3 lets channel 0 return to state2
// - state1 lets channel 0 jump to state3
// - channel 0 usable from every state
// - matchers a and c match the same address independently
// - per channel choice of immediate or tagged transition
// - breakpoint request raised on entering final state
package dtss_pkg;
   // =============================
   // sizes
   localparam int DTSS_NUM_CH = 3;        // match channels 0..2
   localparam int DTSS_CTL_W = 4;         // bits per state control word
   // =============================
   // control word fields
   localparam int DTSS_CTL_CODE_LSB = 0;  // low three bits: legacy code
   localparam int DTSS_CTL_ALT_BIT = 3;   // extra bit: channel 0 alternate jump
   localparam logic [2:0] DTSS_C_CH0_NEXT = 3'h0;    // ch0 -> next state
   localparam logic [2:0] DTSS_C_CH1_NEXT = 3'h1;    // ch1 -> next state
   localparam logic [2:0] DTSS_C_CH2_NEXT = 3'h2;    // ch2 -> next state
   localparam logic [2:0] DTSS_C_CH0_FIN = 3'h3;     // ch0 -> final
   localparam logic [2:0] DTSS_C_CH1_FIN = 3'h4;     // ch1 -> final
   localparam logic [2:0] DTSS_C_CH2_FIN = 3'h5;     // ch2 -> final
   localparam logic [2:0] DTSS_C_CH0N_CH1F = 3'h6;   // ch0 next, ch1 final
   localparam logic [2:0] DTSS_C_CH1N_CH2F = 3'h7;   // ch1 next, ch2 final
   // =============================
   // reset values
   localparam logic [3:0] DTSS_CTL_RST = 4'h0;       // control words after reset
   // =============================
   // types
   typedef enum logic [2:0] {DTSS_IDLE, DTSS_S1, DTSS_S2, DTSS_S3, DTSS_FINAL} dtss_state_t;
   typedef struct packed {
      logic hit;            // channel asks for a transition
      dtss_state_t nxt;     // where it leads
   } dtss_tgt_t;
endpackage

// ---- rtl/dtss_chan_if.sv ----
`timescale 1ns/1ps
// =============================
// per-channel signals between sequencer and tag trackers
interface dtss_chan_if;
   logic [2:0] match;     // raw matches, channel 1 already range-masked
   logic [2:0] tag_en;    // 1: tag the opcode instead of immediate
   logic [2:0] tag_hit;   // tagged opcode reached execution
   logic armed;           // sequencer armed
   logic [2:0] evt;       // resolved transition events
   logic [2:0] tag_req;   // ask the queue to tag the opcode
   modport seq (output match, output tag_en, output tag_hit, output armed,
                input evt, input tag_req);
   modport trk (input match, input tag_en, input tag_hit, input armed,
                output evt, output tag_req);
endinterface

// ---- rtl/dtss_tag_track.sv ----
`timescale 1ns/1ps
module dtss_tag_track
   import dtss_pkg::*;
#(
   parameter int NUM_CH = DTSS_NUM_CH
) (
   input wire logic clk_sys,
   input wire logic nrst,
   dtss_chan_if.trk ch
);
   // =============================
   // elaboration check
   if (NUM_CH != DTSS_NUM_CH) begin : g_bad
      $error("dtss_tag_track supports exactly three channels");
   end
   // =============================
   // one pending-tag flag per channel
   genvar i;
   for (i = 0; i < NUM_CH; i++) begin : g_ch
      logic pend_r;    // opcode tagged, waiting for execution
      logic pend_nxt;
      // pending flag: set by tagged match, cleared by its hit or disarm
      always_comb begin
         pend_nxt = pend_r;
         if (!ch.armed) begin
            pend_nxt = 1'b0;
         end else if (ch.tag_en[i] && ch.match[i]) begin
            pend_nxt = 1'b1;   // new tag wins over a coinciding hit
         end else if (ch.tag_hit[i]) begin
            pend_nxt = 1'b0;
         end
      end
      always_ff @(posedge clk_sys) begin
         if (!nrst) begin
            pend_r <= 1'b0;
         end else begin
            pend_r <= pend_nxt;
         end
      end
      // immediate mode passes the match, tagged mode waits for the hit
      assign ch.evt[i] = ch.armed & (ch.tag_en[i] ? (ch.tag_hit[i] & pend_r) : ch.match[i]);
      assign ch.tag_req[i] = ch.armed & ch.tag_en[i] & ch.match[i];
      // a tag that survives two quiet cycles must still fire on its hit
      tag_fire_a: assert property (@(posedge clk_sys) disable iff (!nrst)
         ch.armed && ch.tag_en[i] && ch.match[i] && !ch.tag_hit[i]
         ##1 (ch.armed && ch.tag_en[i] && !ch.tag_hit[i]) [*2]
         ##1 ch.armed && ch.tag_en[i] && ch.tag_hit[i] |-> ch.evt[i])
         else $error("tagged hit did not raise its event");
   end
endmodule

// ---- testbench/dtss_queue_model.sv ----
`timescale 1ns/1ps
// ==========================
// core queue model: a tagged opcode reaches execution some cycles later
module dtss_queue_model (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [2:0] tag_req,
   input wire logic slow,
   output logic [2:0] tag_hit
);
   logic [3:0] cnt_r [3]; // cycles left per channel
   // count down and pulse at one; slow mode stalls the queue longer
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < 3; i++) begin
         tag_hit[i] <= nrst && cnt_r[i] == 4'h1;
         if (!nrst) begin
            cnt_r[i] <= 4'h0;
         end else if (tag_req[i]) begin
            cnt_r[i] <= slow ? 4'h9 : 4'h2;
         end else if (cnt_r[i] != 4'h0) begin
            cnt_r[i] <= cnt_r[i] - 4'h1;
         end
      end
   end
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
// ==========================
// bench: drives events, queues expected states, watcher compares
module tb_top
   import dtss_pkg::*;
();
   logic clk_sys, nrst, arm, range_ab, brk_en, slow, in_final, brk_req;
   logic match_ch0, match_ch1, match_ch2;
   logic [3:0] ctl1, ctl2, ctl3;
   logic [2:0] tag_en, tag_hit, tag_req, seq_state, exp_st, last_st;
   logic [3:0] notes [$]; // {break expected, state}
   logic [3:0] nt;
   int n_mismatch, checked, cyc, seed;
   dtss_seq dtss_seq_i (.clk_sys(clk_sys), .nrst(nrst), .arm(arm),
      .sequencer_state_ctl1(ctl1), .sequencer_state_ctl2(ctl2),
      .sequencer_state_ctl3(ctl3), .match_ch0(match_ch0), .match_ch1(match_ch1),
      .match_ch2(match_ch2),
      .range_ab(range_ab), .tag_en(tag_en), .tag_hit(tag_hit), .brk_en(brk_en),
      .tag_req(tag_req), .seq_state(seq_state), .in_final(in_final), .brk_req(brk_req));
   dtss_queue_model dtss_queue_model_i (.clk_sys(clk_sys), .nrst(nrst),
      .tag_req(tag_req), .slow(slow), .tag_hit(tag_hit));
   // ==========================
   // reference next state; 0 in a target means no hit
   function automatic logic [2:0] go(logic [2:0] s, logic [3:0] c, logic [2:0] m);
      logic [2:0] nx, al, t0, t1, t2;
      nx = (s == 3'h3) ? 3'h4 : s + 3'h1;
      al = (s == 3'h1) ? 3'h3 : s - 3'h1; // alternate jump of channel 0
      t0 = (c[2:0] == 3'h0 || c[2:0] == 3'h6) ? nx : (c[2:0] == 3'h3) ? 3'h4 : 3'h0;
      t0 = c[3] ? al : t0;
      t1 = (c[2:0] == 3'h1 || c[2:0] == 3'h7) ? nx : (c[2:0] == 3'h4) ? 3'h4 : 3'h0;
      t1 = (c[2:0] == 3'h6) ? 3'h4 : t1;
      t2 = (c[2:0] == 3'h2) ? nx : (c[2:0] == 3'h5 || c[2:0] == 3'h7) ? 3'h4 : 3'h0;
      t0 = m[0] ? t0 : 3'h0;
      t1 = m[1] ? t1 : 3'h0;
      t2 = m[2] ? t2 : 3'h0;
      if (t0 == 3'h4 || t1 == 3'h4 || t2 == 3'h4) return 3'h4;
      return (t0 != 3'h0) ? t0 : (t1 != 3'h0) ? t1 : (t2 != 3'h0) ? t2 : s;
   endfunction
   task automatic chk(logic ok, string msg);
      checked++;
      if (!ok) begin
         n_mismatch++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask
   task automatic results();
      $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one cycle of arm and matches, called in the rising-edge step;
   // the expectation is worked out at the falling edge, after any
   // configuration written in the same step has settled
   task automatic ev(logic a, logic [2:0] m);
      logic [2:0] e, t, k;
      arm <= a;
      {match_ch2, match_ch1, match_ch0} <= m;
      @(negedge clk_sys);
      k = m & {1'b1, ~range_ab, 1'b1};
      t = a ? k & tag_en : 3'h0;
      if (!a) e = DTSS_IDLE;
      else if (exp_st == DTSS_IDLE) e = DTSS_S1;
      else if (exp_st == DTSS_FINAL) e = DTSS_FINAL;
      else e = go(exp_st, exp_st == 3'h1 ? ctl1 : exp_st == 3'h2 ? ctl2 : ctl3, k);
      if (e !== exp_st) notes.push_back({brk_en && e == 3'h4, e});
      exp_st = e;
      chk(tag_req === t, "tag request");
      @(posedge clk_sys);
   endtask
   // ==========================
   // watcher: each state change takes the oldest note
   always @(negedge clk_sys) begin
      if (nrst === 1'b1 && seq_state !== last_st) begin
         last_st = seq_state;
         if (notes.size() == 0) begin
            chk(1'b0, "unexpected state change");
         end else begin
            nt = notes.pop_front();
            chk(seq_state === nt[2:0], "wrong state");
            chk(brk_req === nt[3] && in_final === (nt[2:0] == 3'h4), "break");
         end
      end
   end
   // clock, 50 ns period
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // hang guard, a few thousand cycles is ample
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         results();
      end
   end
   initial begin
      {nrst, arm, range_ab, brk_en, slow, match_ch0, match_ch1, match_ch2} = 8'h10;
      {ctl1, ctl2, ctl3, tag_en} = 15'h0000;
      {exp_st, last_st} = 6'h00;
      seed = 12953;
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      ctl2 <= 4'h5;
      // match in the first armed cycle and in final are ignored
      ev(1, 3'h1);
      ev(1, 3'h1);
      ev(1, 3'h4);
      ev(1, 3'h7);
      ev(0, 3'h0);
      $display("test walk done");
      {brk_en, ctl1, ctl2, ctl3} <= 13'h080D;
      ev(1, 3'h0);
      ev(1, 3'h1);
      ev(1, 3'h1);
      ev(1, 3'h1);
      ev(1, 3'h5);
      ev(0, 3'h0);
      $display("test alternate jumps done");
      // forks in state1 and state2: the lowest channel decides
      {brk_en, ctl1, ctl2} <= 9'h199;
      ev(1, 3'h0);
      ev(1, 3'h3);
      ev(1, 3'h1);
      ev(1, 3'h3);
      {range_ab, ctl1} <= 5'h14;
      ev(1, 3'h2);
      ev(1, 3'h2);
      ev(0, 3'h0);
      $display("test priority and range done");
      {range_ab, ctl1, tag_en} <= 8'h01;
      for (int s = 0; s < 2; s++) begin
         slow <= s[0];
         ev(1, 3'h0);
         ev(1, 3'h1);
         repeat (14) ev(1, 3'h0);
         ev(0, 3'h0);
      end
      tag_en <= 3'h0;
      $display("test tagged done");
      repeat (400) begin
         {ctl1, ctl2, ctl3} <= 12'($random(seed));
         {range_ab, brk_en} <= 2'($random(seed));
         ev(exp_st != DTSS_FINAL, 3'($random(seed)));
      end
      ev(0, 3'h0);
      repeat (3) @(posedge clk_sys);
      // a state change that never came leaves its note behind
      chk(notes.size() == 0, "expected state change never seen");
      $display("test random done");
      results();
   end
endmodule
